//--- hdl/pss_map.svh
// Purpose: shared constants for the pipelined synchronous memory port
// Assumes: included by bare name from the package and the design modules
// Notes: definitions only, no logic
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// ----------------------------------------------------------------------
// organisation
// ----------------------------------------------------------------------
`define PSS_ADDR_W 19
`define PSS_LANES 4
`define PSS_LANE_W 9
`define PSS_BURST_W 2

// ----------------------------------------------------------------------
// burst counter field, reset and step values
// ----------------------------------------------------------------------
`define PSS_BURST_LSB 0
`define PSS_BURST_RST 2'h0
`define PSS_BURST_ONE 2'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PSS_CLK_PERIOD_NS 50
`define PSS_READ_LATENCY 2

`endif

//--- hdl/pss_pkg.sv
// Purpose: types shared by the memory port modules
// Assumes: pss_map.svh supplies the numeric constants
// Notes: state codes are written out in binary
package pss_pkg;
    `include "pss_map.svh"

    // ------------------------------------------------------------------
    // port state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSS_ST_DESEL = 2'b00,
        PSS_ST_ACTIVE = 2'b01,
        PSS_ST_SLEEP = 2'b10
    } pss_state_type;

    // ------------------------------------------------------------------
    // decoded command of one clock edge
    // ------------------------------------------------------------------
    typedef struct packed {
        logic load;
        logic desel;
        logic step;
        logic write;
        logic read;
    } pss_cmd_type;
endpackage : pss_pkg

//--- hdl/pss_burst_counter.sv
// Purpose: two-bit burst counter giving the low word address of a burst
// Assumes: seed is the two low address bits taken with the strobe
// Notes: offset_nxt is combinational so the edge that steps also uses it
`include "pss_map.svh"
module pss_burst_counter
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [`PSS_BURST_W-1:0] seed,
    input wire logic step,
    input wire logic interleaved,
    output logic [`PSS_BURST_W-1:0] offset_nxt,
    output logic [`PSS_BURST_W-1:0] offset_r
);
    logic [`PSS_BURST_W-1:0] seed_r;
    logic [`PSS_BURST_W-1:0] count_r;
    logic [`PSS_BURST_W-1:0] seed_nxt;
    logic [`PSS_BURST_W-1:0] count_nxt;

    // ------------------------------------------------------------------
    // order mapping
    // ------------------------------------------------------------------
    // wraps inside the four-word group either way
    function automatic logic [`PSS_BURST_W-1:0] map_offset(
        input logic [`PSS_BURST_W-1:0] s,
        input logic [`PSS_BURST_W-1:0] c,
        input logic il
    );
        map_offset = il ? (s ^ c) : `PSS_BURST_W'(s + c);
    endfunction : map_offset

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // a load restarts the sequence from the seed
    always_comb begin
        seed_nxt = load ? seed : seed_r;
        if (load) begin
            count_nxt = `PSS_BURST_RST;
        end else if (step) begin
            count_nxt = `PSS_BURST_W'(count_r + `PSS_BURST_ONE);
        end else begin
            count_nxt = count_r;
        end
        offset_nxt = map_offset(seed_nxt, count_nxt, interleaved);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seed_r <= `PSS_BURST_RST;
            count_r <= `PSS_BURST_RST;
            offset_r <= `PSS_BURST_RST;
        end else begin
            seed_r <= seed_nxt;
            count_r <= count_nxt;
            offset_r <= offset_nxt;
        end
    end
endmodule : pss_burst_counter

//--- hdl/pss_sram_port.sv
// Purpose: synchronous pipelined burst static memory, device side
// Assumes: all inputs but out_enable_n and sleep_request are synchronous to ref_clk
// Notes: storage is flip-flops; reset clears control state, never contents
`include "pss_map.svh"
module pss_sram_port
    import pss_pkg::*;
#(
    parameter int ADDR_W = `PSS_ADDR_W,
    parameter int LANES = `PSS_LANES,
    parameter int LANE_W = `PSS_LANE_W,
    parameter bit SINGLE_SELECT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic primary_select_n,
    input wire logic expand_select_hi,
    input wire logic expand_select_lo_n,
    input wire logic [LANES-1:0] byte_lane_select_n,
    input wire logic byte_write_gate_n,
    input wire logic all_lanes_write_n,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic burst_interleaved,
    input wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic dq_oe,
    output logic sleeping
);
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // the burst counter owns the two low bits, so the address must be wider
    generate
        if (ADDR_W <= `PSS_BURST_W || ADDR_W > 24) begin : g_bad_addr
            $error("pss_sram_port: ADDR_W out of range");
        end
        if (LANES < 1 || LANE_W < 1) begin : g_bad_lanes
            $error("pss_sram_port: LANES and LANE_W must be positive");
        end
    endgenerate

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];
    pss_state_type state_r;
    pss_state_type state_nxt;
    pss_cmd_type cmd;
    logic [ADDR_W-1:`PSS_BURST_W] base_r;
    logic [ADDR_W-1:`PSS_BURST_W] base_nxt;
    logic [`PSS_BURST_W-1:0] offset_nxt;
    logic [ADDR_W-1:0] eff_addr;
    logic [LANES-1:0] lane_mask;
    logic selected;
    logic cpu_go;
    logic ctrl_go;
    logic strobe;
    logic in_burst;
    logic [DATA_W-1:0] read_stage_r;
    logic read_stage_valid_r;
    logic drive_ok_r;

    // ------------------------------------------------------------------
    // select and strobe decode
    // ------------------------------------------------------------------
    // the third select is forced active for the single-select package
    assign selected = ~primary_select_n & expand_select_hi
                      & (SINGLE_SELECT | ~expand_select_lo_n);
    assign cpu_go = ~cpu_addr_strobe_n & ~primary_select_n;
    assign ctrl_go = ~ctrl_addr_strobe_n & ~cpu_go;
    assign strobe = cpu_go | ctrl_go;
    assign in_burst = (state_r == PSS_ST_ACTIVE) & ~strobe;

    // ------------------------------------------------------------------
    // lane decode
    // ------------------------------------------------------------------
    // global write overrides the per-lane selects and the gate
    function automatic logic [LANES-1:0] lanes_of(
        input logic gw_n,
        input logic gate_n,
        input logic [LANES-1:0] sel_n
    );
        if (!gw_n) begin
            lanes_of = '1;
        end else if (!gate_n) begin
            lanes_of = ~sel_n;
        end else begin
            lanes_of = '0;
        end
    endfunction : lanes_of

    assign lane_mask = lanes_of(all_lanes_write_n, byte_write_gate_n, byte_lane_select_n);

    // ------------------------------------------------------------------
    // command of this edge
    // ------------------------------------------------------------------
    // a selected processor strobe opens a read unless sleep is requested; its write data follows on
    // a later edge without a strobe, which keeps the bus turnaround clean
    always_comb begin
        cmd = '0;
        if (!sleep_request) begin
            cmd.load = strobe & selected;
            cmd.desel = strobe & ~selected;
            cmd.step = in_burst & ~burst_step_n;
            cmd.write = (in_burst | (cmd.load & ctrl_go)) & (|lane_mask);
            cmd.read = (in_burst | cmd.load) & ~cmd.write;
        end
    end

    // ------------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------------
    pss_burst_counter u_burst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .load(cmd.load),
        .seed(addr[`PSS_BURST_W-1:0]),
        .step(cmd.step),
        .interleaved(burst_interleaved),
        .offset_nxt(offset_nxt),
        .offset_r()
    );

    // ------------------------------------------------------------------
    // address register
    // ------------------------------------------------------------------
    // upper bits hold through a burst; the counter supplies the low bits
    assign base_nxt = cmd.load ? addr[ADDR_W-1:`PSS_BURST_W] : base_r;
    assign eff_addr = {base_nxt, offset_nxt};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            base_r <= '0;
        end else begin
            base_r <= base_nxt;
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // sleep wins over any strobe; leaving sleep returns deselected
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSS_ST_DESEL: begin
                if (sleep_request) begin
                    state_nxt = PSS_ST_SLEEP;
                end else if (cmd.load) begin
                    state_nxt = PSS_ST_ACTIVE;
                end
            end
            PSS_ST_ACTIVE: begin
                if (sleep_request) begin
                    state_nxt = PSS_ST_SLEEP;
                end else if (cmd.desel) begin
                    state_nxt = PSS_ST_DESEL;
                end
            end
            PSS_ST_SLEEP: begin
                if (!sleep_request) begin
                    state_nxt = PSS_ST_DESEL;
                end
            end
            default: begin
                state_nxt = PSS_ST_DESEL;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= PSS_ST_DESEL;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sleeping = (state_r == PSS_ST_SLEEP);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // contents are untouched by reset and by sleep
    always_ff @(posedge ref_clk) begin
        if (cmd.write) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_mask[i]) begin
                    mem_r[eff_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read pipeline
    // ------------------------------------------------------------------
    // array read at the read edge, output register on the next edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_stage_valid_r <= 1'b0;
            read_stage_r <= '0;
        end else begin
            read_stage_valid_r <= cmd.read;
            if (cmd.read) begin
                read_stage_r <= mem_r[eff_addr];
            end
        end
    end

    // output word only follows a valid array read
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dq_out <= '0;
            drive_ok_r <= 1'b0;
        end else begin
            drive_ok_r <= read_stage_valid_r & ~sleep_request;
            if (read_stage_valid_r) begin
                dq_out <= read_stage_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin direction
    // ------------------------------------------------------------------
    // combinational so the enable acts without the clock; after a
    // deselect drive_ok_r is low for the whole first read clock
    assign dq_oe = ~out_enable_n & drive_ok_r & ~sleep_request;
endmodule : pss_sram_port

//--- test/pss_sram_port_properties.sv
// Purpose: pin-level checks on the memory port
// Assumes: bound to pss_sram_port, one clock, sync reset
// Notes: strobe decode is redone here from the pins
module pss_port_props
    import pss_pkg::*;
#(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter bit SINGLE_SELECT = 1'h0
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic cpu_addr_strobe_n,
    input logic ctrl_addr_strobe_n,
    input logic burst_step_n,
    input logic primary_select_n,
    input logic expand_select_hi,
    input logic expand_select_lo_n,
    input logic [LANES-1:0] byte_lane_select_n,
    input logic byte_write_gate_n,
    input logic all_lanes_write_n,
    input logic out_enable_n,
    input logic sleep_request,
    input logic [LANES*LANE_W-1:0] dq_out,
    input logic dq_oe,
    input logic sleeping
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // --------
    // decode
    // --------
    logic sel, stb, cpu_ok, mask, rd_ld, wr_ld, idle, wr_go;
    // cpu strobe only counts with the first select low
    assign cpu_ok = !cpu_addr_strobe_n && !primary_select_n;
    assign sel = !primary_select_n && expand_select_hi && (!expand_select_lo_n || SINGLE_SELECT);
    assign stb = !sleep_request && (!ctrl_addr_strobe_n || cpu_ok);
    assign mask = !all_lanes_write_n || (!byte_write_gate_n && (byte_lane_select_n != '1));
    assign wr_ld = stb && sel && !cpu_ok && mask;
    assign rd_ld = stb && sel && !wr_ld;
    assign idle = cpu_addr_strobe_n && ctrl_addr_strobe_n;
    assign wr_go = idle && mask && !burst_step_n && !sleep_request;
    // --------
    // assertions
    // --------
    sleep_quiet_a: assert property (sleep_request |-> !dq_oe)
        else $error("data pins driven while asleep");
    oe_gate_a: assert property (out_enable_n |-> !dq_oe)
        else $error("data pins driven with output enable high");
    sleep_enter_a: assert property ($rose(sleep_request) |=> sleeping)
        else $error("sleep state not entered");
    sleep_exit_a: assert property ($fell(sleep_request) |=> !sleeping)
        else $error("sleep state not left");
    reset_clear_a: assert property ($past(sys_rst) |-> !dq_oe && dq_out == '0 && !sleeping)
        else $error("outputs not cleared by reset");
    desel_quiet_a: assert property (stb && !sel ##1 idle [*2] |=> !dq_oe && $stable(dq_out))
        else $error("output after deselect");
    read_drive_a: assert property (rd_ld ##1 rd_ld ##1 !out_enable_n [*2] |-> ##1 (dq_oe || out_enable_n))
        else $error("read data not driven two edges after load");
    write_quiet_a: assert property (wr_ld ##1 wr_go [*2] |-> ##1 !dq_oe)
        else $error("write burst drove the data pins");
endmodule : pss_port_props

bind pss_sram_port pss_port_props #(.LANES(LANES), .LANE_W(LANE_W), .SINGLE_SELECT(SINGLE_SELECT)) u_props (
    .ref_clk, .sys_rst, .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .primary_select_n,
    .expand_select_hi, .expand_select_lo_n, .byte_lane_select_n, .byte_write_gate_n, .all_lanes_write_n,
    .out_enable_n, .sleep_request, .dq_out, .dq_oe, .sleeping);

//--- test/pss_host_model.sv
// Purpose: processor or cache controller driving the memory bus
// Assumes: one bus cycle per call, driven at the falling edge
// Notes: idle address and data lines are scrambled, never held
module pss_host_model
    import pss_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input logic ref_clk,
    output logic [ADDR_W-1:0] addr,
    output logic cpu_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_step_n,
    output logic primary_select_n,
    output logic expand_select_hi,
    output logic expand_select_lo_n,
    output logic [3:0] byte_lane_select_n,
    output logic byte_write_gate_n,
    output logic all_lanes_write_n,
    output logic out_enable_n,
    output logic sleep_request,
    output logic burst_interleaved,
    output logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet bus at time zero
    initial begin
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, primary_select_n} = 4'hF;
        {expand_select_hi, expand_select_lo_n, byte_write_gate_n, all_lanes_write_n} = 4'h3;
        byte_lane_select_n = 4'hF;
        {out_enable_n, sleep_request, burst_interleaved} = 3'h0;
        addr = '0;
        dq_in = 36'h0;
    end

    // s = {cpu, ctrl, step}, ce = selects, w = {global, gate, lanes}
    task automatic cycle(input logic [2:0] s, input logic [2:0] ce, input logic [ADDR_W-1:0] a,
                         input logic [5:0] w, input logic [35:0] d);
        @(negedge ref_clk);
        {cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = s;
        {primary_select_n, expand_select_hi, expand_select_lo_n} = ce;
        addr = (s[2] && s[1]) ? ~addr : a;
        {all_lanes_write_n, byte_write_gate_n, byte_lane_select_n} = w;
        // no write this edge: the data lines carry no stale word
        dq_in = (w[5] && w[4]) ? ~dq_in : d;
    endtask : cycle
endmodule : pss_host_model

//--- test/pss_sram_port_tb.sv
// Purpose: self-checking bench for the memory port
// Assumes: small address width keeps the flop array short
// Notes: read data is checked one edge after its load edge
module pss_sram_port_tb
    import pss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;
    localparam logic [2:0] CTRL = 3'h5, CPU = 3'h3, BOTH = 3'h1, STEP = 3'h6, IDLE = 3'h7, CPS = 3'h2;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [5:0] GW = 6'h1F, NOW = 6'h3F, BY = 6'h2A, GOFF = 6'h30;
    localparam logic [35:0] LM = 36'h0_07FC_01FF;
    localparam logic [35:0] D [8] = '{36'h1_1111_1111, 36'h2_2222_2222, 36'h3_3333_3333,
        36'h4_4444_4444, 36'hE_EEEE_EEEE, 36'h5_A5A5_A5A5, 36'hA_5A5A_5A5A, 36'hF_0F0F_0F0F};
    logic ref_clk, sys_rst, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, primary_select_n;
    logic expand_select_hi, expand_select_lo_n, byte_write_gate_n, all_lanes_write_n, out_enable_n;
    logic sleep_request, burst_interleaved, dq_oe, sleeping;
    logic [AW-1:0] addr;
    logic [3:0] byte_lane_select_n;
    logic [35:0] dq_in, dq_out, dq_out_single;
    int num_errors = 0;
    int tests_run = 0;

    pss_sram_port #(.ADDR_W(AW)) u_dut (.*);
    // same pins into the single-select variant, where the third select never deselects
    pss_sram_port #(.ADDR_W(AW), .SINGLE_SELECT(1'h1)) u_dut_single (
        .*,
        .dq_out(dq_out_single),
        .dq_oe(),
        .sleeping()
    );
    pss_host_model #(.ADDR_W(AW)) u_host (.*);

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    // --------
    // helpers
    // --------
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic idle();
        u_host.cycle(IDLE, SEL, '0, NOW, 36'h0);
    endtask : idle

    // single read; first flags a read straight out of deselect
    task automatic rd(input logic [AW-1:0] a, input logic [35:0] exp, input bit first);
        u_host.cycle(CTRL, SEL, a, NOW, 36'h0);
        @(posedge ref_clk) #1;
        if (first) check(dq_oe, 36'h0);
        idle();
        @(posedge ref_clk) #1;
        check(dq_out, exp);
        check(dq_oe, 36'h1);
        @(negedge ref_clk) u_host.out_enable_n = 1'h1;
        #1 check(dq_oe, 36'h0);
        u_host.out_enable_n = 1'h0;
    endtask : rd
    // --------
    // scenarios
    // --------
    task automatic t_burst();
        u_host.cycle(CTRL, SEL, 6'h08, GW, D[0]);
        for (int i = 1; i < 4; i++) u_host.cycle(STEP, SEL, '0, GW, D[i]);
        u_host.cycle(STEP, SEL, '0, BY, D[4]);
        rd(6'h08, (D[4] & LM) | (D[0] & ~LM), 0);
        for (int i = 1; i < 4; i++) rd(6'h08 + AW'(i), D[i], 0);
    endtask : t_burst

    task automatic t_interleave();
        @(negedge ref_clk) u_host.burst_interleaved = 1'h1;
        u_host.cycle(CTRL, SEL, 6'h11, GW, D[5]);
        u_host.cycle(STEP, SEL, '0, GW, D[6]);
        // idle first so the step write is sampled with burst_interleaved still high
        idle();
        u_host.burst_interleaved = 1'h0;
        rd(6'h10, D[6], 0);
        rd(6'h11, D[5], 0);
    endtask : t_interleave

    task automatic t_strobes();
        u_host.cycle(CPU, SEL, 6'h0A, NOW, 36'h0);
        u_host.cycle(BOTH, SEL, 6'h09, GW, D[7]);
        @(posedge ref_clk) #1 check(dq_out, D[2]);
        idle();
        @(posedge ref_clk) #1 check(dq_out, D[1]);
        check(dq_oe, 36'h1);
    endtask : t_strobes

    task automatic t_cpu_ignored();
        u_host.cycle(CTRL, SEL, 6'h22, GW, D[2]);
        u_host.cycle(CTRL, SEL, 6'h20, GW, D[0]);
        u_host.cycle(CPS, 3'h6, 6'h30, GW, D[1]);
        u_host.cycle(STEP, SEL, '0, GOFF, D[3]);
        rd(6'h21, D[1], 0);
        rd(6'h22, D[2], 0);
    endtask : t_cpu_ignored

    task automatic t_deselect();
        logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
        foreach (bad[i]) begin
            u_host.cycle(CTRL, bad[i], 6'h21, GW, D[7]);
            idle();
            idle();
            rd(6'h21, D[1], 1);
        end
        check(dq_out_single, D[7]);
    endtask : t_deselect

    task automatic t_sleep();
        @(negedge ref_clk) u_host.sleep_request = 1'h1;
        u_host.cycle(CTRL, SEL, 6'h21, GW, D[7]);
        @(posedge ref_clk) #1 check(sleeping, 36'h1);
        check(dq_oe, 36'h0);
        // strobe goes idle on the same edge that sleep drops, so nothing is taken on wake
        idle();
        u_host.sleep_request = 1'h0;
        @(posedge ref_clk) #1 check(sleeping, 36'h0);
        rd(6'h21, D[1], 1);
    endtask : t_sleep

    // watchdog: the whole run is under a hundred edges
    initial begin
        repeat (4000) @(posedge ref_clk);
        num_errors++;
        $display("[FAIL] t=%0t watchdog seen=%h exp=%h", $time, 1'h1, 1'h0);
        finish_test();
    end

    initial begin
        sys_rst = 1'h1;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) sys_rst = 1'h0;
        #1 check(dq_out, 36'h0);
        check({dq_oe, sleeping}, 36'h0);
        t_burst();
        t_interleave();
        t_strobes();
        t_cpu_ignored();
        t_deselect();
        t_sleep();
        finish_test();
    end
endmodule : pss_sram_port_tb
